// [core/dual_image_upgrade_regs.v]
// Register front end for the remote upgrade and dual image configuration logic
`timescale 1ns/1ps
`include "upgrade_regs_map.vh"
module dual_image_upgrade_regs
(
  input wire clk,
  input wire nrst,
  input wire [2:0] address,
  input wire write,
  input wire [31:0] writedata,
  input wire read,
  output reg [31:0] readdata,
  output wire upgrade_block_clock,
  output wire upgrade_shift,
  output wire upgrade_capture,
  output wire upgrade_update,
  output wire upgrade_din,
  input wire upgrade_dout,
  output reg [1:0] upgrade_source,
  output wire upgrade_reconfig_n,
  output wire upgrade_timer_reset_n
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WRITE = 2'h1;
  localparam ST_READ = 2'h2;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [3:0] rd_pending;
  reg [3:0] next_rd_pending;
  reg ld_pending;
  reg in_override;
  reg in_select;
  reg [1:0] next_source;
  reg sh_start;
  reg sh_update;
  reg [5:0] sh_len;
  reg [1:0] pick_source;
  reg [3:0] pick_mask;

  reg [11:0] wdog_value;
  reg wdog_state;
  reg [3:0] cur_msm;
  reg [3:0] app1_src;
  reg [3:0] app1_msm;
  reg [3:0] app2_src;
  reg [3:0] app2_msm;
  reg rb_override;
  reg rb_select;
  reg [31:0] next_readdata;

  wire busy;
  wire seq_busy;
  wire queue_busy;
  wire sh_busy;
  wire sh_done;
  wire [`FRAME_MSB:0] sh_rx;
  wire wr_trigger;
  wire wr_load;
  wire wr_readout;
  wire [3:0] readout_req;
  wire trig_reconfig;
  wire trig_timer;
  wire load_start;
  wire read_done;
  wire done_wdog;
  wire done_app1;
  wire done_app2;
  wire done_input;
  wire [31:0] word_busy;
  wire [31:0] word_current;
  wire [31:0] word_app1;
  wire [31:0] word_app2;
  wire [31:0] word_input;

  // Engine flag folded in so busy never drops while a frame is on the wire
  assign seq_busy = (state != ST_IDLE) | sh_busy;
  // Busy covers the queued request too, so it is high the cycle after the write
  assign queue_busy = ld_pending | (|rd_pending);
  assign busy = seq_busy | queue_busy; // RULE4 RULE5 RULE6

  assign wr_trigger = write & (address == `OFS_TRIGGER);
  assign wr_load = write & (address == `OFS_IMAGE_LOAD) & ~busy; // RULE4 RULE7
  assign wr_readout = write & (address == `OFS_READOUT) & ~busy; // RULE7
  assign readout_req = writedata[`RD_INPUT:`RD_WDOG]; // RULE5

  // Triggers decode straight from the bus so they land in the write cycle itself
  assign trig_reconfig = wr_trigger & writedata[`BIT_RECONFIG] & ~busy; // RULE1 RULE7
  // Watchdog restart is never held off by busy, or a long readout could starve it
  assign trig_timer = wr_trigger & writedata[`BIT_WDOG_RESTART]; // RULE1 RULE7
  assign upgrade_reconfig_n = ~trig_reconfig; // RULE2
  assign upgrade_timer_reset_n = ~trig_timer; // RULE2

  assign load_start = sh_start & sh_update;
  assign read_done = sh_done & (state == ST_READ);
  assign done_wdog = read_done & (upgrade_source == `SRC_WDOG); // RULE18
  assign done_app2 = read_done & (upgrade_source == `SRC_APP2); // RULE18
  assign done_app1 = read_done & (upgrade_source == `SRC_APP1); // RULE18
  assign done_input = read_done & (upgrade_source == `SRC_INPUT); // RULE18

  // Each word is zero outside its own fields, so reserved bits read zero
  assign word_busy = {31'h0, busy}; // RULE6 RULE14
  assign word_current = {15'h0, cur_msm, wdog_state, wdog_value}; // RULE9 RULE14
  assign word_app1 = {24'h0, app1_msm, app1_src}; // RULE11 RULE14
  assign word_app2 = {24'h0, app2_msm, app2_src}; // RULE12 RULE14
  assign word_input = {30'h0, rb_select, rb_override}; // RULE13 RULE14

  // The upgrade clock is clk halved while a frame runs and sits low otherwise; nothing here slows a frame down,
  // so clk must stay within twice the upgrade block's own clock limit
  upgrade_shifter u_shifter
  (
    .clk(clk),
    .nrst(nrst),
    .start(sh_start),
    .update(sh_update),
    .len(sh_len),
    .tx_data({in_select, in_override}),
    .busy(sh_busy),
    .done(sh_done),
    .rx_data(sh_rx),
    .upgrade_block_clock(upgrade_block_clock),
    .upgrade_shift(upgrade_shift),
    .upgrade_capture(upgrade_capture),
    .upgrade_update(upgrade_update),
    .upgrade_din(upgrade_din),
    .upgrade_dout(upgrade_dout)
  );

  // Readouts run lowest bit first, one frame per source in a fixed order
  always @*
  begin
    pick_source = `SRC_WDOG;
    pick_mask = 4'h0;
    if (rd_pending[`RD_WDOG])
    begin
      pick_source = `SRC_WDOG;
      pick_mask[`RD_WDOG] = 1'b1;
    end
    else if (rd_pending[`RD_APP2])
    begin
      pick_source = `SRC_APP2;
      pick_mask[`RD_APP2] = 1'b1;
    end
    else if (rd_pending[`RD_APP1])
    begin
      pick_source = `SRC_APP1;
      pick_mask[`RD_APP1] = 1'b1;
    end
    else if (rd_pending[`RD_INPUT])
    begin
      pick_source = `SRC_INPUT;
      pick_mask[`RD_INPUT] = 1'b1;
    end
  end

  // Sequencer: a pending image load goes first, then readouts lowest bit first
  always @*
  begin
    next_state = state;
    next_rd_pending = rd_pending;
    next_source = upgrade_source;
    sh_start = 1'b0;
    sh_update = 1'b0;
    sh_len = `FRAME_BITS;
    case (state)
      ST_IDLE:
      begin
        if (ld_pending)
        begin
          sh_start = 1'b1;
          sh_update = 1'b1;
          sh_len = `WRITE_BITS;
          next_state = ST_WRITE;
        end
        else if (|rd_pending)
        begin
          sh_start = 1'b1;
          next_state = ST_READ;
          next_source = pick_source;
          next_rd_pending = rd_pending & ~pick_mask;
        end
      end
      ST_WRITE:
      begin
        if (sh_done)
          next_state = ST_IDLE;
      end
      ST_READ:
      begin
        if (sh_done)
          next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
    if (wr_readout)
      next_rd_pending = readout_req; // RULE5
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // Pending readouts drain one bit per frame
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rd_pending <= 4'h0;
    else
      rd_pending <= next_rd_pending;
  end

  // Source stays put through the frame so the capture knows where to land
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      upgrade_source <= `SRC_WDOG;
    else
      upgrade_source <= next_source;
  end

  // Local copy of the image settings; it feeds the serial write frame
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      in_override <= 1'b0;
      in_select <= 1'b0;
    end
    else if (wr_load)
    begin
      in_override <= writedata[`BIT_OVERRIDE]; // RULE3
      in_select <= writedata[`BIT_IMAGE_SEL]; // RULE3
    end
  end

  // Load request waits here until the sequencer starts its write frame
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ld_pending <= 1'b0;
    else if (wr_load)
      ld_pending <= 1'b1; // RULE4
    else if (load_start)
      ld_pending <= 1'b0;
  end

  // Readback capture; each group changes only when its own frame finishes
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wdog_value <= 12'h000;
      wdog_state <= 1'b0;
      cur_msm <= 4'h0;
    end
    else if (done_wdog)
    begin
      // Only the upper bits of the count fit the register
      wdog_value <= sh_rx[`WDOG_TOP_MSB:`WDOG_TOP_LSB]; // RULE10
      wdog_state <= sh_rx[`WDOG_STATE_BIT]; // RULE9
      cur_msm <= sh_rx[`MSM_MSB:0]; // RULE9
    end
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      app2_src <= 4'h0;
      app2_msm <= 4'h0;
    end
    else if (done_app2)
    begin
      app2_msm <= sh_rx[`PREV_MSM_MSB:`PREV_MSM_LSB]; // RULE12
      app2_src <= sh_rx[`MSM_MSB:0]; // RULE12
    end
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      app1_src <= 4'h0;
      app1_msm <= 4'h0;
    end
    else if (done_app1)
    begin
      app1_msm <= sh_rx[`PREV_MSM_MSB:`PREV_MSM_LSB]; // RULE11
      app1_src <= sh_rx[`MSM_MSB:0]; // RULE11
    end
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rb_override <= 1'b0;
      rb_select <= 1'b0;
    end
    else if (done_input)
    begin
      // Value held in the block's input register, not the select pin
      rb_override <= sh_rx[`BIT_OVERRIDE]; // RULE13
      rb_select <= sh_rx[`BIT_IMAGE_SEL]; // RULE13
    end
  end

  // Read mux; write-only offsets and reserved bits return zero
  always @*
  begin
    next_readdata = 32'h00000000; // RULE14
    case (address)
      `OFS_BUSY:
        next_readdata = word_busy; // RULE6
      `OFS_CURRENT:
        next_readdata = word_current; // RULE9
      `OFS_PREV_APP1:
        next_readdata = word_app1; // RULE11
      `OFS_PREV_APP2:
        next_readdata = word_app2; // RULE12
      `OFS_INPUT_REG:
        next_readdata = word_input; // RULE13
      default:
        next_readdata = 32'h00000000;
    endcase
  end

  // Read data is held between reads, so a slow master still sees its answer
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      readdata <= 32'h00000000;
    else if (read)
      readdata <= next_readdata;
  end
endmodule // dual_image_upgrade_regs

// [core/upgrade_regs_map.vh]
// Register map, field positions and frame constants for the dual image upgrade front end
// Summary of operation
// RULE1: Offset 0 bit 0 requests reconfiguration, bit 1 restarts the user watchdog.
// RULE2: Offset 0 trigger outputs assert during the same bus write cycle.
// RULE3: Offset 1 loads override from bit 0 and image select from bit 1.
// RULE4: Busy rises right after an offset 1 write; further offset 1 writes ignored.
// RULE5: Offset 2 starts readouts: watchdog, app 2, app 1, input register; busy follows.
// RULE6: Offset 3 bit 0 reads busy, high during any upgrade block process.
// RULE7: While busy all upgrade writes are dropped except the watchdog restart.
// RULE8: Master should poll busy after triggering before issuing further operations.
// RULE9: Offset 4 holds watchdog value 11:0, watchdog state 12, master state 16:13.
// RULE10: Offset 4 watchdog value is the top 12 bits of the 29-bit count.
// RULE11: Offset 5 holds app 1 source in 3:0, master state in 7:4.
// RULE12: Offset 6 holds app 2 source in 3:0, master state in 7:4.
// RULE13: Offset 7 returns stored override bit 0 and image select bit 1.
// RULE14: Reserved bits read zero; master should write zero to them.
// RULE15: Master writes one to trigger an operation; zero triggers nothing.
// RULE16: Master triggers the matching offset 2 readout before reading offsets 4 to 7.
// RULE17: Upgrade block clock runs at half the bus clock rate.
// RULE18: Captured readback values hold until the next readout of that source.
`ifndef UPGRADE_REGS_MAP_VH
`define UPGRADE_REGS_MAP_VH
`define OFS_TRIGGER 3'h0
`define OFS_IMAGE_LOAD 3'h1
`define OFS_READOUT 3'h2
`define OFS_BUSY 3'h3
`define OFS_CURRENT 3'h4
`define OFS_PREV_APP1 3'h5
`define OFS_PREV_APP2 3'h6
`define OFS_INPUT_REG 3'h7
`define BIT_RECONFIG 0
`define BIT_WDOG_RESTART 1
`define BIT_OVERRIDE 0
`define BIT_IMAGE_SEL 1
`define RD_WDOG 0
`define RD_APP2 1
`define RD_APP1 2
`define RD_INPUT 3
`define BIT_BUSY 0
`define SRC_WDOG 2'h0
`define SRC_APP2 2'h1
`define SRC_APP1 2'h2
`define SRC_INPUT 2'h3
`define FRAME_BITS 6'h22
`define WRITE_BITS 6'h02
`define FRAME_MSB 33
`define WDOG_TOP_MSB 33
`define WDOG_TOP_LSB 22
`define WDOG_STATE_BIT 4
`define MSM_MSB 3
`define PREV_MSM_MSB 7
`define PREV_MSM_LSB 4
`endif

// [core/upgrade_shifter.v]
// Serial frame engine that clocks the upgrade block at half the bus clock rate
`timescale 1ns/1ps
`include "upgrade_regs_map.vh"
module upgrade_shifter
(
  input wire clk,
  input wire nrst,
  input wire start,
  input wire update,
  input wire [5:0] len,
  input wire [1:0] tx_data,
  output wire busy,
  output reg done,
  output reg [`FRAME_MSB:0] rx_data,
  output wire upgrade_block_clock,
  output wire upgrade_shift,
  output reg upgrade_capture,
  output reg upgrade_update,
  output wire upgrade_din,
  input wire upgrade_dout
);
  reg running;
  reg phase;
  reg is_update;
  reg [5:0] count;
  reg [1:0] tx;

  // Clock is a plain flop toggling each bus cycle of a frame and held low between frames, so it never glitches
  assign upgrade_block_clock = phase; // RULE17
  assign upgrade_shift = running & ~is_update;
  assign upgrade_din = tx[1];
  assign busy = running;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      running <= 1'b0;
      phase <= 1'b0;
      is_update <= 1'b0;
      count <= 6'h00;
      tx <= 2'h0;
      rx_data <= {(`FRAME_MSB+1){1'b0}};
      done <= 1'b0;
      upgrade_capture <= 1'b0;
      upgrade_update <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      upgrade_capture <= 1'b0;
      upgrade_update <= 1'b0;
      if (!running)
      begin
        phase <= 1'b0;
        if (start)
        begin
          running <= 1'b1;
          is_update <= update;
          count <= len;
          tx <= tx_data;
          upgrade_capture <= ~update;
        end
      end
      else
      begin
        phase <= ~phase; // RULE17
        if (!phase)
        begin
          // Sample on the cycle that raises the upgrade clock
          if (!is_update)
            rx_data <= {rx_data[`FRAME_MSB-1:0], upgrade_dout};
        end
        else
        begin
          count <= count - 6'h01;
          tx <= {tx[0], 1'b0};
          if (count == 6'h01)
          begin
            running <= 1'b0;
            done <= 1'b1;
            upgrade_update <= is_update;
          end
        end
      end
    end
  end
endmodule // upgrade_shifter

// [test/upgrade_regs_chk.sv]
// Port-level assertions for the upgrade register front end
`timescale 1ns/1ps
module upgrade_regs_chk
(
  input wire clk,
  input wire nrst,
  input wire [2:0] address,
  input wire write,
  input wire [31:0] writedata,
  input wire read,
  input wire [31:0] readdata,
  input wire upgrade_block_clock,
  input wire upgrade_shift,
  input wire upgrade_reconfig_n,
  input wire upgrade_timer_reset_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  reconfig_cause_a:
    assert property (!upgrade_reconfig_n |-> write && address == 3'h0 && writedata[0])
    else $error("reconfig low without trigger write");
  timer_same_a:
    assert property (!upgrade_timer_reset_n == (write && address == 3'h0 && writedata[1]))
    else $error("timer restart not in write cycle");
  read_hold_a:
    assert property (!read |=> $stable(readdata))
    else $error("readdata moved without read");
  busy_rsv_a:
    assert property (read && address == 3'h3 |=> readdata[31:1] == 31'h0)
    else $error("busy reserved bits set");
  state_rsv_a:
    assert property (read && address == 3'h4 |=> readdata[31:17] == 15'h0)
    else $error("state reserved bits set");
  prev_rsv_a:
    assert property (read && (address == 3'h5 || address == 3'h6) |=> readdata[31:8] == 24'h0)
    else $error("previous app reserved bits set");
  input_rsv_a:
    assert property (read && address == 3'h7 |=> readdata[31:2] == 30'h0)
    else $error("input reserved bits set");
  wo_read_a:
    assert property (read && address < 3'h3 |=> readdata == 32'h0)
    else $error("write-only offset read nonzero");
  half_rate_a:
    assert property (upgrade_block_clock |=> !upgrade_block_clock)
    else $error("upgrade clock high two cycles");
  clk_toggle_a:
    assert property (upgrade_shift && !upgrade_block_clock |=> upgrade_block_clock)
    else $error("upgrade clock missed a rising phase");
endmodule // upgrade_regs_chk
bind dual_image_upgrade_regs upgrade_regs_chk u_chk
(
  .clk(clk),
  .nrst(nrst),
  .address(address),
  .write(write),
  .writedata(writedata),
  .read(read),
  .readdata(readdata),
  .upgrade_block_clock(upgrade_block_clock),
  .upgrade_shift(upgrade_shift),
  .upgrade_reconfig_n(upgrade_reconfig_n),
  .upgrade_timer_reset_n(upgrade_timer_reset_n)
);

// [test/upgrade_block_model.sv]
// Behavioural model of the serial upgrade block
`timescale 1ns/1ps
module upgrade_block_model #(
  parameter [33:0] WDOG_FRAME = 34'h0,
  parameter [33:0] APP1_FRAME = 34'h0,
  parameter [33:0] APP2_FRAME = 34'h0
)
(
  input wire clk,
  input wire upgrade_block_clock,
  input wire upgrade_shift,
  input wire upgrade_capture,
  input wire upgrade_update,
  input wire upgrade_din,
  input wire [1:0] upgrade_source,
  output reg upgrade_dout
);
  reg [33:0] sr = 34'h0;
  reg [1:0] wr_sr = 2'h0;
  reg [1:0] input_reg = 2'h0;
  initial upgrade_dout = 1'b0;
  // Mid high phase: away from the bus clock edge that moves din and samples dout
  always @(negedge clk)
  begin
    if (upgrade_capture)
    begin
      case (upgrade_source)
        2'h0: sr = WDOG_FRAME;
        2'h1: sr = APP2_FRAME;
        2'h2: sr = APP1_FRAME;
        default: sr = {32'h0, input_reg};
      endcase
      upgrade_dout = sr[33];
    end
    else if (upgrade_shift && upgrade_block_clock)
    begin
      sr = {sr[32:0], 1'b0};
      upgrade_dout = sr[33];
    end
    else if (!upgrade_shift)
      upgrade_dout = ~upgrade_dout;
    if (!upgrade_shift && upgrade_block_clock)
      wr_sr = {wr_sr[0], upgrade_din};
    if (upgrade_update)
      input_reg = wr_sr;
  end
endmodule // upgrade_block_model

// [test/test_dual_image_upgrade_regs.sv]
// Self-checking testbench for the upgrade register front end
`timescale 1ns/1ps
module test_dual_image_upgrade_regs;
  localparam [33:0] WDOG = 34'h2a5c3e96b;
  localparam [33:0] APP1 = 34'h3ffffff5a;
  localparam [33:0] APP2 = 34'h3ffffffa7;
  localparam [31:0] E4 = {15'h0, WDOG[3:0], WDOG[4], WDOG[33:22]};
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg [2:0] address = 3'h0;
  reg write = 1'b0;
  reg [31:0] writedata = 32'h0;
  reg read = 1'b0;
  reg [31:0] rv;
  wire [31:0] readdata;
  wire ublk, ushift, ucap, uupd, udin, udout, rcfg_n, tmr_n;
  wire [1:0] usrc;
  integer errors = 0;
  integer cmp_count = 0;
  always #2.5 clk = ~clk;
  dual_image_upgrade_regs u_dut (.clk(clk), .nrst(nrst), .address(address),
    .write(write), .writedata(writedata), .read(read), .readdata(readdata),
    .upgrade_block_clock(ublk), .upgrade_shift(ushift), .upgrade_capture(ucap),
    .upgrade_update(uupd), .upgrade_din(udin), .upgrade_dout(udout),
    .upgrade_source(usrc), .upgrade_reconfig_n(rcfg_n), .upgrade_timer_reset_n(tmr_n));
  upgrade_block_model #(.WDOG_FRAME(WDOG), .APP1_FRAME(APP1), .APP2_FRAME(APP2)) u_far
    (.clk(clk), .upgrade_block_clock(ublk), .upgrade_shift(ushift),
    .upgrade_capture(ucap), .upgrade_update(uupd), .upgrade_din(udin),
    .upgrade_source(usrc), .upgrade_dout(udout));
  task test_done;
  begin
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  task chk(input [63:0] name, input [31:0] exp, input [31:0] got);
  begin
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("Error %0s expected %h seen %h", name, exp, got);
    end
  end
  endtask
  task wr(input [2:0] a, input [31:0] d);
  begin
    @(negedge clk);
    address = a;
    writedata = d;
    write = 1'b1;
    @(negedge clk);
    write = 1'b0;
    writedata = 32'h0;
  end
  endtask
  task rd(input [2:0] a);
  begin
    @(negedge clk);
    address = a;
    read = 1'b1;
    @(negedge clk);
    read = 1'b0;
    rv = readdata;
  end
  endtask
  task wait_idle;
    integer n;
  begin
    n = 0;
    rv = 32'h1;
    while (rv[0] !== 1'b0 && n < 600)
    begin
      rd(3'h3);
      n = n + 1;
    end
    if (rv[0] !== 1'b0)
    begin
      errors = errors + 1;
      $display("Error busy expected 0 seen %h", rv);
      test_done;
    end
  end
  endtask
  // Zero-valued bit writes must not fire either trigger
  task t_trig;
  begin
    @(negedge clk);
    address = 3'h0;
    writedata = 32'h3;
    write = 1'b1;
    #1;
    chk("rcfg", 32'h0, {31'h0, rcfg_n});
    chk("tmr", 32'h0, {31'h0, tmr_n});
    @(negedge clk);
    writedata = 32'h0;
    #1;
    chk("rcfg0", 32'h1, {31'h0, rcfg_n});
    chk("tmr0", 32'h1, {31'h0, tmr_n});
    @(negedge clk);
    write = 1'b0;
    $display("t_trig done");
  end
  endtask
  task t_image;
  begin
    wr(3'h1, 32'h2);
    wait_idle;
    wr(3'h2, 32'h8);
    wait_idle;
    rd(3'h7);
    chk("inreg", 32'h2, rv);
    $display("t_image done");
  end
  endtask
  task t_busy;
  begin
    wr(3'h2, 32'hf);
    @(negedge clk);
    address = 3'h0;
    writedata = 32'h3;
    write = 1'b1;
    #1;
    chk("rcfgb", 32'h1, {31'h0, rcfg_n});
    chk("tmrb", 32'h0, {31'h0, tmr_n});
    @(negedge clk);
    write = 1'b0;
    wr(3'h1, 32'h1);
    rd(3'h3);
    chk("busy", 32'h1, rv);
    wait_idle;
    rd(3'h4);
    chk("state", E4, rv);
    rd(3'h5);
    chk("app1", {24'h0, APP1[7:0]}, rv);
    rd(3'h6);
    chk("app2", {24'h0, APP2[7:0]}, rv);
    rd(3'h7);
    chk("inreg2", 32'h2, rv);
    $display("t_busy done");
  end
  endtask
  task t_hold;
  begin
    wr(3'h2, 32'h8);
    wait_idle;
    rd(3'h4);
    chk("hold", E4, rv);
    rd(3'h0);
    chk("wo", 32'h0, rv);
    $display("t_hold done");
  end
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    t_trig;
    t_image;
    t_busy;
    t_hold;
    test_done;
  end
endmodule // test_dual_image_upgrade_regs
